// ### logic/dws_defs.vh
/*
 * dws_defs.vh: register map, field positions, reset values and encodings for the
 * waveform sequencer.
 * Assumes it is included by bare name from logic/ design files.
 */
`ifndef DWS_DEFS_VH
`define DWS_DEFS_VH

// register byte offsets
`define DWS_REG_CTRL      12'h000
`define DWS_REG_CMD       12'h004
`define DWS_REG_UI        12'h008
`define DWS_REG_UC        12'h00C
`define DWS_REG_IC        12'h010
`define DWS_REG_DLY1      12'h014
`define DWS_REG_DLY2      12'h018
`define DWS_REG_TRIG      12'h01C
`define DWS_REG_STATUS    12'h020
`define DWS_REG_PLEN      12'h024
`define DWS_REG_SAMPLES   12'h028
`define DWS_ADDR_W        12

// control register fields
`define DWS_CTRL_START_SRC_LO  0
`define DWS_CTRL_START_SRC_HI  1
`define DWS_CTRL_STOP_SRC_LO   2
`define DWS_CTRL_STOP_SRC_HI   3
`define DWS_CTRL_STRB_SRC_LO   4
`define DWS_CTRL_STRB_SRC_HI   5
`define DWS_CTRL_DLY1_CLK_LO   6
`define DWS_CTRL_DLY1_CLK_HI   7
`define DWS_CTRL_DLY2_CLK_LO   8
`define DWS_CTRL_DLY2_CLK_HI   9
`define DWS_CTRL_STOP_MODE_LO  10
`define DWS_CTRL_STOP_MODE_HI  11
`define DWS_CTRL_DELAY_EN      12
`define DWS_CTRL_RETRIG_EN     13
`define DWS_CTRL_ITER_EN       14
`define DWS_CTRL_DLY2_EN       15
`define DWS_CTRL_CH_EN_LO      16
`define DWS_CTRL_CH_EN_HI      19
`define DWS_CTRL_W             20
`define DWS_CTRL_RST           20'h00000

// command register bits (write 1 to act, self clearing)
`define DWS_CMD_SW_START  0
`define DWS_CMD_SW_STOP   1
`define DWS_CMD_TRIG_RST  2

// source encodings
`define DWS_SRC_SW     2'h0
`define DWS_SRC_EXT    2'h1
`define DWS_SRC_ANA    2'h2
`define DWS_SRC_SYNC   2'h3
`define DWS_UPD_INT    2'h0
`define DWS_UPD_EXT    2'h1
`define DWS_UPD_SYNC   2'h2
`define DWS_CLK_TB     2'h0
`define DWS_CLK_AUX    2'h1
`define DWS_CLK_GT0    2'h2
`define DWS_CLK_GT1    2'h3
`define DWS_STOP_NOW   2'h0
`define DWS_STOP_PER   2'h1
`define DWS_STOP_ITER  2'h2

// counter widths and reset values
`define DWS_W24        24
`define DWS_W16        16
`define DWS_UI_RST     24'h000028
`define DWS_UC_RST     24'h000004
`define DWS_IC_RST     16'h0001
`define DWS_D_RST      16'h0000
`define DWS_TRIG_RST   16'h0001
`define DWS_PLEN_RST   16'h0004
`define DWS_CODE_W     12
`define DWS_CH_N       4

// timebase: one enable per 100/40 MHz, made by a fractional accumulator
`define DWS_TB_ADD     4'h4
`define DWS_TB_MOD     4'hA

// ahb codes
`define DWS_HTRANS_NONSEQ 2'h2
`define DWS_HSIZE_WORD    3'h2
`endif

// ### logic/dws_sequencer.v
/*
 * dws_sequencer.v: waveform sequencer for one converter group, with an AHB-Lite
 * register slave, start/stop/trigger handling, six counters and the group's
 * converter write strobe.
 * Assumes a sample source that presents a code word per enabled channel with
 * valid, a pattern address it follows, and inputs synchronous to hclk.
 */
// The AHB-Lite slave port and the placing of the registers were chosen for this implementation.
// How it works
// - start, write strobe and stop events govern generation.
// - samples load into converters on the write strobe falling edge; three strobe sources.
// - stop source selects software, external digital or analog trigger.
// - 24-bit update interval counts 40 MHz timebase ticks between samples.
// - 24-bit count of samples per waveform period.
// - 16-bit iteration count repeats periods in any trigger mode.
// - delay mode counts 16-bit start delay down on clock rises, then outputs.
// - start delay clock picks timebase, aux input, or general timer 0 or 1.
// - iterative mode counts the 16-bit gap after each period, then continues.
// - gap clock picks timebase, aux input, or general timer 0 or 1.
// - retrigger limits honoured starts to a 16-bit count until trigger reset.
// - start triggers during generation are ignored.
// - post-trigger outputs update count times iteration count samples per start.
// - with iteration counting off, generation runs until a stop trigger.
// - a pattern fitting the buffer replays; longer ones are refilled by the source.
// - periods take consecutive pattern slices and wrap at pattern end.
// - first stop mode halts at once.
// - second stop mode finishes the current period, then stops.
// - third stop mode finishes all programmed iterations, then stops.
// - a readable generation active flag shows when generation stopped.
// - group outputs change only after every enabled channel code is latched.
// - timing, trigger and stop settings are shared by the whole group.
`timescale 1ns/1ps
`include "dws_defs.vh"

module dws_sequencer (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    input wire ext_start_trig,
    input wire ext_stop_trig,
    input wire analog_trig,
    input wire sync_start_trig,
    input wire ext_update,
    input wire sync_update,
    input wire aux_function_input_zero,
    input wire general_timer_out0,
    input wire general_timer_out1,
    input wire [47:0] sample_codes,
    input wire sample_valid,
    output reg sample_take,
    output reg [15:0] pattern_addr,
    output reg [47:0] dac_codes,
    output reg [3:0] dac_load,
    output reg converter_write_strobe,
    output reg generation_active_flag
);

    localparam ST_IDLE = 3'h0;
    localparam ST_DLY1 = 3'h1;
    localparam ST_RUN = 3'h2;
    localparam ST_DLY2 = 3'h3;

    // 4:1 source picker, used for start, stop and both delay clocks
    function pick4;
        input [1:0] sel;
        input a;
        input b;
        input c;
        input d;
        begin
            case (sel)
                2'h0: pick4 = a;
                2'h1: pick4 = b;
                2'h2: pick4 = c;
                default: pick4 = d;
            endcase
        end
    endfunction

    reg [`DWS_CTRL_W-1:0] ctrl_ff;
    reg [23:0] ui_ff;
    reg [23:0] uc_ff;
    reg [15:0] ic_ff;
    reg [15:0] dly1_ff;
    reg [15:0] dly2_ff;
    reg [15:0] trig_ff;
    reg [15:0] plen_ff;
    reg [2:0] state_ff;
    reg [23:0] ui_cnt_ff;
    reg [23:0] uc_cnt_ff;
    reg [15:0] ic_cnt_ff;
    reg [15:0] dly_cnt_ff;
    reg [15:0] trig_cnt_ff;
    reg [31:0] samples_ff;
    reg stop_pend_ff;
    reg strobe_low_ff;
    reg [3:0] tb_acc_ff;
    reg tb_tick_ff;
    reg d1_prev_ff;
    reg d2_prev_ff;
    reg upd_prev_ff;
    reg cmd_start_ff;
    reg cmd_stop_ff;
    reg cmd_trst_ff;
    reg wr_pend_ff;
    reg rd_pend_ff;
    reg [`DWS_ADDR_W-1:0] addr_ff;

    wire [1:0] start_src = ctrl_ff[`DWS_CTRL_START_SRC_HI:`DWS_CTRL_START_SRC_LO];
    wire [1:0] stop_src = ctrl_ff[`DWS_CTRL_STOP_SRC_HI:`DWS_CTRL_STOP_SRC_LO];
    wire [1:0] strb_src = ctrl_ff[`DWS_CTRL_STRB_SRC_HI:`DWS_CTRL_STRB_SRC_LO];
    wire [1:0] d1_src = ctrl_ff[`DWS_CTRL_DLY1_CLK_HI:`DWS_CTRL_DLY1_CLK_LO];
    wire [1:0] d2_src = ctrl_ff[`DWS_CTRL_DLY2_CLK_HI:`DWS_CTRL_DLY2_CLK_LO];
    wire [1:0] stop_mode = ctrl_ff[`DWS_CTRL_STOP_MODE_HI:`DWS_CTRL_STOP_MODE_LO];
    wire delay_en = ctrl_ff[`DWS_CTRL_DELAY_EN];
    wire retrig_en = ctrl_ff[`DWS_CTRL_RETRIG_EN];
    wire iter_en = ctrl_ff[`DWS_CTRL_ITER_EN];
    wire dly2_en = ctrl_ff[`DWS_CTRL_DLY2_EN];
    wire [3:0] ch_en = ctrl_ff[`DWS_CTRL_CH_EN_HI:`DWS_CTRL_CH_EN_LO];

    // events
    wire start_evt = pick4(start_src, cmd_start_ff, ext_start_trig, analog_trig,
        sync_start_trig);
    wire stop_evt = pick4(stop_src, cmd_stop_ff, ext_stop_trig, analog_trig,
        1'b0);
    wire d1_lvl = pick4(d1_src, tb_tick_ff, aux_function_input_zero,
        general_timer_out0, general_timer_out1);
    wire d2_lvl = pick4(d2_src, tb_tick_ff, aux_function_input_zero,
        general_timer_out0, general_timer_out1);
    // the timebase tick is already a pulse; external clocks are edge detected
    wire d1_tick = (d1_src == `DWS_CLK_TB) ? tb_tick_ff : (d1_lvl & ~d1_prev_ff);
    wire d2_tick = (d2_src == `DWS_CLK_TB) ? tb_tick_ff : (d2_lvl & ~d2_prev_ff);
    wire upd_lvl = (strb_src == `DWS_UPD_EXT) ? ext_update : sync_update;
    wire upd_tick = (strb_src == `DWS_UPD_INT) ? (tb_tick_ff && ui_cnt_ff <= 24'h000001)
        : (upd_lvl & ~upd_prev_ff);
    wire trig_full = retrig_en && (trig_cnt_ff >= trig_ff);
    wire idle = (state_ff == ST_IDLE);
    wire accept = idle && start_evt && !trig_full && !cmd_trst_ff;
    // every enabled channel must have a code before the group strobe fires
    wire codes_ready = sample_valid;
    // an immediate stop wins over a sample in the same cycle, so nothing half-loads
    wire sample_fire = (state_ff == ST_RUN) && upd_tick && codes_ready && strobe_low_ff == 1'b0
        && !(stop_evt && stop_mode == `DWS_STOP_NOW);
    wire period_end = sample_fire && (uc_cnt_ff <= 24'h000001);
    wire last_iter = iter_en && (ic_cnt_ff <= 16'h0001);
    wire stop_now = stop_evt && stop_mode == `DWS_STOP_NOW && !idle;
    wire stop_flag = stop_pend_ff || stop_evt;
    wire finish_per = period_end && stop_flag && stop_mode == `DWS_STOP_PER;
    wire finish_iter = period_end && last_iter;
    // a stop in iteration mode without counting only ends at a period boundary
    wire finish_inf = period_end && stop_flag && stop_mode == `DWS_STOP_ITER && !iter_en;

    // timebase enable: 4 ticks per 10 hclk cycles gives 40 MHz on average
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tb_acc_ff <= 4'h0;
            tb_tick_ff <= 1'b0;
        end else if (tb_acc_ff + `DWS_TB_ADD >= `DWS_TB_MOD) begin
            tb_acc_ff <= tb_acc_ff + `DWS_TB_ADD - `DWS_TB_MOD;
            tb_tick_ff <= 1'b1;
        end else begin
            tb_acc_ff <= tb_acc_ff + `DWS_TB_ADD;
            tb_tick_ff <= 1'b0;
        end
    end

    // AHB-Lite slave, zero wait states, always OKAY
    wire ahb_go = hsel && hready && htrans == `DWS_HTRANS_NONSEQ;
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_ff <= 1'b0;
            rd_pend_ff <= 1'b0;
            addr_ff <= 12'h000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            wr_pend_ff <= ahb_go && hwrite;
            rd_pend_ff <= ahb_go && !hwrite;
            if (ahb_go) begin
                addr_ff <= haddr[`DWS_ADDR_W-1:0];
            end
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // read data is registered in the address phase so hrdata comes from a flop
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h00000000;
        end else if (ahb_go && !hwrite) begin
            case (haddr[`DWS_ADDR_W-1:0])
                `DWS_REG_CTRL: hrdata <= {12'h000, ctrl_ff};
                `DWS_REG_UI: hrdata <= {8'h00, ui_ff};
                `DWS_REG_UC: hrdata <= {8'h00, uc_ff};
                `DWS_REG_IC: hrdata <= {16'h0000, ic_ff};
                `DWS_REG_DLY1: hrdata <= {16'h0000, dly1_ff};
                `DWS_REG_DLY2: hrdata <= {16'h0000, dly2_ff};
                `DWS_REG_TRIG: hrdata <= {16'h0000, trig_ff};
                `DWS_REG_STATUS: hrdata <= {9'h000, state_ff, trig_cnt_ff,
                    2'h0, trig_full, generation_active_flag};
                `DWS_REG_PLEN: hrdata <= {16'h0000, plen_ff};
                `DWS_REG_SAMPLES: hrdata <= samples_ff;
                default: hrdata <= 32'h00000000;
            endcase
        end
    end

    // configuration registers, one set for the whole group
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_ff <= `DWS_CTRL_RST;
            ui_ff <= `DWS_UI_RST;
            uc_ff <= `DWS_UC_RST;
            ic_ff <= `DWS_IC_RST;
            dly1_ff <= `DWS_D_RST;
            dly2_ff <= `DWS_D_RST;
            trig_ff <= `DWS_TRIG_RST;
            plen_ff <= `DWS_PLEN_RST;
            cmd_start_ff <= 1'b0;
            cmd_stop_ff <= 1'b0;
            cmd_trst_ff <= 1'b0;
        end else begin
            cmd_start_ff <= 1'b0;
            cmd_stop_ff <= 1'b0;
            cmd_trst_ff <= 1'b0;
            if (wr_pend_ff) begin
                case (addr_ff)
                    `DWS_REG_CTRL: ctrl_ff <= hwdata[`DWS_CTRL_W-1:0];
                    `DWS_REG_CMD: begin
                        cmd_start_ff <= hwdata[`DWS_CMD_SW_START];
                        cmd_stop_ff <= hwdata[`DWS_CMD_SW_STOP];
                        cmd_trst_ff <= hwdata[`DWS_CMD_TRIG_RST];
                    end
                    `DWS_REG_UI: ui_ff <= hwdata[23:0];
                    `DWS_REG_UC: uc_ff <= hwdata[23:0];
                    `DWS_REG_IC: ic_ff <= hwdata[15:0];
                    `DWS_REG_DLY1: dly1_ff <= hwdata[15:0];
                    `DWS_REG_DLY2: dly2_ff <= hwdata[15:0];
                    `DWS_REG_TRIG: trig_ff <= hwdata[15:0];
                    `DWS_REG_PLEN: plen_ff <= hwdata[15:0];
                    default: ;
                endcase
            end
        end
    end

    // sequencer
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_ff <= ST_IDLE;
            ui_cnt_ff <= `DWS_UI_RST;
            uc_cnt_ff <= `DWS_UC_RST;
            ic_cnt_ff <= `DWS_IC_RST;
            dly_cnt_ff <= `DWS_D_RST;
            trig_cnt_ff <= 16'h0000;
            samples_ff <= 32'h00000000;
            stop_pend_ff <= 1'b0;
            d1_prev_ff <= 1'b0;
            d2_prev_ff <= 1'b0;
            upd_prev_ff <= 1'b0;
            pattern_addr <= 16'h0000;
            generation_active_flag <= 1'b0;
        end else begin
            d1_prev_ff <= d1_lvl;
            d2_prev_ff <= d2_lvl;
            upd_prev_ff <= upd_lvl;
            if (cmd_trst_ff) begin
                trig_cnt_ff <= 16'h0000;
            end else if (accept && retrig_en) begin
                trig_cnt_ff <= trig_cnt_ff + 16'h0001;
            end
            if (state_ff == ST_RUN && tb_tick_ff) begin
                // reload on expiry keeps the interval exact
                ui_cnt_ff <= (ui_cnt_ff <= 24'h000001) ? ui_ff : ui_cnt_ff - 24'h000001;
            end
            if (stop_evt && !idle) begin
                stop_pend_ff <= 1'b1;
            end
            case (state_ff)
                ST_IDLE: begin
                    generation_active_flag <= 1'b0;
                    stop_pend_ff <= 1'b0;
                    if (accept) begin
                        ui_cnt_ff <= ui_ff;
                        uc_cnt_ff <= uc_ff;
                        ic_cnt_ff <= ic_ff;
                        dly_cnt_ff <= dly1_ff;
                        samples_ff <= 32'h00000000;
                        generation_active_flag <= 1'b1;
                        state_ff <= (delay_en && dly1_ff != 16'h0000) ? ST_DLY1 : ST_RUN;
                    end
                end
                ST_DLY1: begin
                    if (stop_now) begin
                        state_ff <= ST_IDLE;
                    end else if (d1_tick) begin
                        dly_cnt_ff <= dly_cnt_ff - 16'h0001;
                        if (dly_cnt_ff == 16'h0001) begin
                            state_ff <= ST_RUN;
                        end
                    end
                end
                ST_RUN: begin
                    if (stop_now) begin
                        state_ff <= ST_IDLE;
                    end else if (sample_fire) begin
                        samples_ff <= samples_ff + 32'h00000001;
                        // wrap at pattern end; next period resumes the slice
                        pattern_addr <= (pattern_addr + 16'h0001 >= plen_ff) ? 16'h0000
                            : pattern_addr + 16'h0001;
                        uc_cnt_ff <= (uc_cnt_ff <= 24'h000001) ? uc_ff : uc_cnt_ff - 24'h000001;
                        if (period_end) begin
                            ic_cnt_ff <= last_iter ? ic_ff : ic_cnt_ff - 16'h0001;
                            if (finish_per || finish_iter || finish_inf) begin
                                state_ff <= ST_IDLE;
                            end else if (dly2_en && dly2_ff != 16'h0000) begin
                                dly_cnt_ff <= dly2_ff;
                                state_ff <= ST_DLY2;
                            end
                        end
                    end
                end
                ST_DLY2: begin
                    if (stop_now) begin
                        state_ff <= ST_IDLE;
                    end else if (d2_tick) begin
                        dly_cnt_ff <= dly_cnt_ff - 16'h0001;
                        if (dly_cnt_ff == 16'h0001) begin
                            ui_cnt_ff <= ui_ff;
                            state_ff <= ST_RUN;
                        end
                    end
                end
                default: state_ff <= ST_IDLE;
            endcase
        end
    end

    // group latch: codes are captured for all enabled channels at once, and the
    // converters load on the strobe's falling edge one cycle later
    genvar g;
    generate
        for (g = 0; g < `DWS_CH_N; g = g + 1) begin : g_ch
            always @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    dac_codes[g*12 +: 12] <= 12'h000;
                    dac_load[g] <= 1'b0;
                end else begin
                    if (sample_fire && ch_en[g]) begin
                        dac_codes[g*12 +: 12] <= sample_codes[g*12 +: 12];
                    end
                    dac_load[g] <= converter_write_strobe && ch_en[g];
                end
            end
        end
    endgenerate

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            converter_write_strobe <= 1'b0;
            strobe_low_ff <= 1'b0;
            sample_take <= 1'b0;
        end else begin
            converter_write_strobe <= sample_fire;
            strobe_low_ff <= sample_fire;
            sample_take <= sample_fire;
        end
    end

endmodule // dws_sequencer

// ### dv/dws_seq_chk.sv
/* dws_seq_chk.sv: port checker for dws_sequencer.
   assumes hclk and hresetn from the bench; bound at the foot. */
`timescale 1ns/1ps
module dws_seq_chk (
    input wire hclk,
    input wire hresetn,
    input wire hreadyout,
    input wire hresp,
    input wire sample_take,
    input wire [15:0] pattern_addr,
    input wire [47:0] dac_codes,
    input wire [3:0] dac_load,
    input wire converter_write_strobe,
    input wire generation_active_flag
);
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    reg [7:0] gap_ff;
    reg seen_ff;
    // gap saturates so long idle spells never wrap into a false short gap
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            gap_ff <= 8'h00;
            seen_ff <= 1'b0;
        end else begin
            gap_ff <= converter_write_strobe ? 8'h00 : gap_ff + {7'h00, gap_ff != 8'hFF};
            seen_ff <= generation_active_flag & (seen_ff | converter_write_strobe);
        end
    end
    sequence s_strobe;
        converter_write_strobe;
    endsequence
    sequence s_quiet;
        !converter_write_strobe;
    endsequence
    a_resp_okay: assert property (hreadyout && !hresp)
        else $error("bus slave not ready or not okay");
    a_strobe_pulse: assert property (s_strobe |=> s_quiet)
        else $error("write strobe wider than one cycle");
    a_strobe_active: assert property (s_strobe |-> generation_active_flag)
        else $error("write strobe outside generation");
    a_load_after: assert property (dac_load != 4'h0 |-> $past(converter_write_strobe))
        else $error("converter load not after strobe fall");
    a_load_pulse: assert property (dac_load != 4'h0 |=> dac_load == 4'h0)
        else $error("converter load wider than one cycle");
    a_codes_held: assert property ($changed(dac_codes) |->
        converter_write_strobe || dac_load != 4'h0 || $past(converter_write_strobe))
        else $error("converter codes moved outside a load");
    a_strobe_space: assert property (s_strobe and seen_ff |-> gap_ff >= 8'h5A)
        else $error("strobes closer than the interval");
    a_addr_step: assert property (generation_active_flag && $past(generation_active_flag)
        && $changed(pattern_addr) |-> sample_take)
        else $error("pattern index moved without a take");
endmodule // dws_seq_chk

bind dws_sequencer dws_seq_chk dws_seq_chk_inst (.hclk(hclk), .hresetn(hresetn),
    .hreadyout(hreadyout), .hresp(hresp), .sample_take(sample_take),
    .pattern_addr(pattern_addr), .dac_codes(dac_codes), .dac_load(dac_load),
    .converter_write_strobe(converter_write_strobe),
    .generation_active_flag(generation_active_flag));

// ### dv/dws_fifo_model.sv
/* dws_fifo_model.sv: sample buffer in front of the sequencer.
   assumes the bench drives stall; codes follow pattern_addr. */
`timescale 1ns/1ps
module dws_fifo_model (
    input wire hclk,
    input wire stall,
    input wire [15:0] pattern_addr,
    input wire sample_take,
    output logic [47:0] sample_codes,
    output logic sample_valid
);
    reg junk_ff = 1'b0;
    always @(posedge hclk) begin
        junk_ff <= ~junk_ff;
    end
    // stalled codes toggle so a stale read never looks right
    always @* begin
        sample_valid = !stall;
        sample_codes = stall ? {48{junk_ff}} : {4{pattern_addr[11:0] ^ 12'hA50}};
    end
endmodule // dws_fifo_model

// ### dv/tb_top.sv
/* tb_top.sv: self-checking bench for dws_sequencer.
   assumes the buffer model beside it and the bound checker. */
`timescale 1ns/1ps
module tb_top;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, stall = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rdv;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [3:0] trig = 4'h0;
    logic [7:0] cnt_ff = 8'h00;
    logic [47:0] sample_codes, dac_codes;
    logic [15:0] pattern_addr;
    logic [3:0] dac_load;
    logic hreadyout, hresp, sample_valid, sample_take, cws, act;
    logic [47:0] exp_q[$];
    logic [11:0] ra[8] = '{12'h000, 12'h008, 12'h00C, 12'h010, 12'h01C, 12'h024, 12'h020, 12'h040};
    logic [31:0] rv[8] = '{32'h0, 32'h28, 32'h4, 32'h1, 32'h1, 32'h4, 32'h0, 32'h0};
    int miscompares = 0, compares = 0, nload = 0, ptr = 0, cyc = 0, n0 = 0;
    always #5 hclk = ~hclk;
    always @(posedge hclk) begin
        cnt_ff <= cnt_ff + 8'h01;
        stall <= ($urandom % 4) == 0;
        cyc = cyc + 1;
        if (cyc == 60000) begin
            miscompares = miscompares + 1;
            wrap_up();
        end
    end
    dws_sequencer dws_sequencer_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .ext_start_trig(trig[0]), .ext_stop_trig(trig[1]), .analog_trig(trig[2]),
        .sync_start_trig(trig[3]), .ext_update(cnt_ff[6]), .sync_update(cnt_ff[6]),
        .aux_function_input_zero(cnt_ff[3]), .general_timer_out0(cnt_ff[4]),
        .general_timer_out1(cnt_ff[5]), .sample_codes(sample_codes),
        .sample_valid(sample_valid), .sample_take(sample_take), .pattern_addr(pattern_addr),
        .dac_codes(dac_codes), .dac_load(dac_load), .converter_write_strobe(cws),
        .generation_active_flag(act));
    dws_fifo_model dws_fifo_model_inst (.hclk(hclk), .stall(stall),
        .pattern_addr(pattern_addr), .sample_take(sample_take),
        .sample_codes(sample_codes), .sample_valid(sample_valid));
    task chk(input logic [47:0] e, input logic [47:0] g);
        compares = compares + 1;
        if (g !== e) begin
            miscompares = miscompares + 1;
            $display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    // loads pop the oldest expected code; a load with nothing expected is an error
    always @(negedge hclk) begin
        if (dac_load !== 4'h0) begin
            nload = nload + 1;
            chk(48'hF, {44'h0, dac_load});
            chk(exp_q.size() ? exp_q.pop_front() : ~dac_codes, dac_codes);
        end
    end
    task ahb(input logic w, input logic [11:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {20'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rdv = hrdata;
    endtask
    task kick(input int b);
        trig[b] <= 1'b1;
        @(posedge hclk);
        trig[b] <= 1'b0;
        @(posedge hclk);
    endtask
    task push(input int n);
        repeat (n) begin
            exp_q.push_back({4{ptr[11:0] ^ 12'hA50}});
            ptr = (ptr + 1) % 4;
        end
    endtask
    task upto(input int n);
        int k;
        k = 0;
        while (nload < n && k < 3000) begin
            @(posedge hclk);
            k = k + 1;
        end
    endtask
    task idle;
        int k;
        k = 0;
        do begin
            repeat (40) @(posedge hclk);
            ahb(1'b0, 12'h020, 32'h0);
            k = k + 1;
        end while (rdv[0] !== 1'b0 && k < 300);
        chk(48'h0, {47'h0, rdv[0]});
        chk(48'h0, 48'(exp_q.size()));
    endtask
    task start(input logic [31:0] ctl, input int n, input int src);
        ahb(1'b1, 12'h000, ctl);
        push(n);
        if (src < 0) ahb(1'b1, 12'h004, 32'h1);
        else kick(src);
        repeat (150) @(posedge hclk);
        ahb(1'b1, 12'h004, 32'h1);
    endtask
    task wrap_up;
        $display("compares=%0d miscompares=%0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        void'($urandom(19285));
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        for (int i = 0; i < 8; i++) begin
            ahb(1'b0, ra[i], 32'h0);
            chk({16'h0, rv[i]}, {16'h0, rdv});
        end
        ahb(1'b1, 12'h040, 32'h5);
        ahb(1'b1, 12'h010, 32'h2);
        ahb(1'b0, 12'h040, 32'h0);
        chk(48'h0, {16'h0, rdv});
        ahb(1'b0, 12'h010, 32'h0);
        chk(48'h2, {16'h0, rdv});
        $display("test registers done");
        ahb(1'b1, 12'h008, 32'h28);
        for (int u = 0; u < 3; u++) begin
            start(32'hF4000 | (u << 4), 8, -1);
            idle();
        end
        $display("test post trigger done");
        ahb(1'b1, 12'h00C, 32'h2);
        ahb(1'b1, 12'h014, 32'h14);
        ahb(1'b1, 12'h018, 32'hA);
        for (int k = 0; k < 4; k++) begin
            start(32'hFD001 | (k << 6) | (k << 8), 4, 0);
            idle();
        end
        $display("test delays done");
        ahb(1'b1, 12'h00C, 32'h4);
        ahb(1'b1, 12'h010, 32'h1);
        ahb(1'b1, 12'h01C, 32'h2);
        repeat (2) begin
            start(32'hF6003, 4, 3);
            idle();
        end
        kick(3);
        repeat (400) @(posedge hclk);
        ahb(1'b0, 12'h020, 32'h0);
        chk(48'h2, {46'h0, rdv[1:0]});
        ahb(1'b1, 12'h004, 32'h4);
        // the trigger reset pulse itself refuses a start in its own cycle
        @(posedge hclk);
        kick(3);
        push(4);
        idle();
        $display("test retrigger done");
        n0 = nload;
        start(32'hF0404, 8, -1);
        upto(n0 + 5);
        kick(1);
        idle();
        ahb(1'b1, 12'h010, 32'h3);
        start(32'hF4808, 12, -1);
        upto(nload + 2);
        kick(2);
        idle();
        start(32'hF0000, 8, -1);
        upto(nload + 2);
        ahb(1'b1, 12'h004, 32'h2);
        repeat (3) @(posedge hclk);
        ahb(1'b0, 12'h020, 32'h0);
        chk(48'h0, {47'h0, rdv[0]});
        exp_q.delete();
        $display("test stop modes done");
        wrap_up();
    end
endmodule // tb_top
